// ===== core/dbs_sequencer.sv
`timescale 1ns/1ns
module dbs_sequencer
  import dbs_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC  // cycles per 0.1 s timer step
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        run_cmd,
  input  wire logic [7:0]  term_in,
  input  wire logic [15:0] cmd_freq,
  input  wire logic [15:0] out_freq,
  output logic             stage_enable,
  output logic             brake_active,
  output logic      [6:0]  brake_level,
  output logic      [7:0]  brake_carrier
);

  // whole module state
  typedef struct packed {
    dbs_state_type state;     // sequencer state
    dbs_kind_type  kind;      // cause of current wait or braking
    logic [9:0]    timer;     // remaining 0.1 s steps
    logic [23:0]   step_cnt;  // timebase divider
    logic          run_prev;  // run command of last cycle
    logic          ext_prev;  // terminal braking of last cycle
    logic [4:0]    ctrl;      // enable, detect, rating, size
    logic [15:0]   thresh;    // threshold frequency
    logic [9:0]    wait_t;    // wait delay
    logic [6:0]    stop_f;    // stop force
    logic [9:0]    stop_d;    // stop duration
    logic [6:0]    start_f;   // start force
    logic [9:0]    start_d;   // start duration
    logic [7:0]    carrier;   // braking carrier
    logic [63:0]   tfunc;     // terminal function codes
    logic [15:0]   rdata;     // read data
    logic          stage;     // output stage on
    logic [6:0]    level;     // braking current
  } dbs_st_type;

  dbs_st_type r_reg;  // registered state
  dbs_st_type r_next; // next state

  logic [NUM_TERM-1:0] term_hit; // terminals asserted with brake function
  logic [1:0]  en;       // enable setting
  logic        det;      // detect setting
  logic        thr_mode; // threshold-only mode
  logic        ext;      // terminal braking request
  logic        ext_rise; // rising edge of it
  logic        run_rise; // rising edge of run
  logic        step;     // one-cycle 0.1 s pulse
  logic        tdone;    // timer expired
  logic        low;      // both frequencies at or below threshold
  logic        hi;       // command at threshold plus hysteresis
  logic        ext_go;   // terminal trigger accepted
  logic [6:0]  fmax;     // force ceiling
  logic [7:0]  cmax;     // carrier ceiling
  logic [6:0]  stop_lv;  // clamped stop force
  logic [6:0]  start_lv; // clamped start force
  logic [16:0] hi_lim;   // threshold plus hysteresis

  // per-terminal function decode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERM; gi++) begin : g_term
      assign term_hit[gi] = term_in[gi] && (r_reg.tfunc[gi*8 +: 8] == FUNC_BRAKE);
    end
  endgenerate

  // setting decode and limits
  always_comb begin
    en       = r_reg.ctrl[CTRL_EN_LSB +: 2];
    det      = r_reg.ctrl[CTRL_DETECT];
    thr_mode = (en == EN_THRESH);
    ext      = (|term_hit) && !thr_mode;
    ext_rise = ext && !r_reg.ext_prev;
    run_rise = run_cmd && !r_reg.run_prev;
    step     = (r_reg.step_cnt == 24'(STEP_CYCLES - 1));
    tdone    = (r_reg.timer == 10'h000);
    low      = (cmd_freq <= r_reg.thresh) && (out_freq <= r_reg.thresh);
    // hysteresis limit for leaving threshold braking
    hi_lim   = {1'b0, r_reg.thresh} + {1'b0, THRESH_HYST};
    hi       = {1'b0, cmd_freq} >= hi_lim;
    // edge or level view of the terminal trigger
    ext_go   = (det == DET_LEVEL) ? ext : ext_rise;
    // force ceiling by rating and unit size
    if (r_reg.ctrl[CTRL_VT]) begin
      fmax = r_reg.ctrl[CTRL_LARGE] ? F_VT_LARGE : F_VT;
      cmax = r_reg.ctrl[CTRL_LARGE] ? CAR_VT_LARGE : CAR_VT;
    end else begin
      fmax = r_reg.ctrl[CTRL_LARGE] ? F_CT_LARGE : F_CT;
      cmax = r_reg.ctrl[CTRL_LARGE] ? CAR_CT_LARGE : CAR_CT;
    end
    stop_lv  = (r_reg.stop_f > fmax) ? fmax : r_reg.stop_f;
    start_lv = (r_reg.start_f > fmax) ? fmax : r_reg.start_f;
  end

  // next-state logic: bus, timebase, sequencer
  always_comb begin
    r_next = r_reg;
    r_next.run_prev = run_cmd;
    r_next.ext_prev = ext;
    r_next.rdata    = 16'h0000;
    // timebase divider and timer step
    r_next.step_cnt = step ? 24'h00_0000 : r_reg.step_cnt + 24'h00_0001;
    // the timer stops at zero and never wraps
    if (step && !tdone) begin
      r_next.timer = r_reg.timer - 10'h001;
    end
    // register writes, threshold, wait and durations clamped to their ranges
    // forces and carrier are kept raw and clamped where used
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        r_next.ctrl = reg_wdata[4:0];
      end else if (reg_addr == REG_THRESH) begin
        r_next.thresh = (reg_wdata > THRESH_MAX) ? THRESH_MAX : reg_wdata;
      end else if (reg_addr == REG_WAIT) begin
        r_next.wait_t = (reg_wdata > {6'h00, WAIT_MAX}) ? WAIT_MAX : reg_wdata[9:0];
      end else if (reg_addr == REG_STOP_FORCE) begin
        r_next.stop_f = reg_wdata[6:0];
      end else if (reg_addr == REG_STOP_DUR) begin
        r_next.stop_d = (reg_wdata > {6'h00, DUR_MAX}) ? DUR_MAX : reg_wdata[9:0];
      end else if (reg_addr == REG_START_FORCE) begin
        r_next.start_f = reg_wdata[6:0];
      end else if (reg_addr == REG_START_DUR) begin
        r_next.start_d = (reg_wdata > {6'h00, DUR_MAX}) ? DUR_MAX : reg_wdata[9:0];
      end else if (reg_addr == REG_CARRIER) begin
        r_next.carrier = reg_wdata[7:0];
      end else if (reg_addr == REG_TERM01) begin
        r_next.tfunc[15:0] = reg_wdata;
      end else if (reg_addr == REG_TERM23) begin
        r_next.tfunc[31:16] = reg_wdata;
      end else if (reg_addr == REG_TERM45) begin
        r_next.tfunc[47:32] = reg_wdata;
      end else if (reg_addr == REG_TERM67) begin
        r_next.tfunc[63:48] = reg_wdata;
      end
    end
    // register reads, unmapped reads as zero
    // status packs the low six timer bits, cause and state of the sequencer
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        r_next.rdata = {11'h000, r_reg.ctrl};
      end else if (reg_addr == REG_THRESH) begin
        r_next.rdata = r_reg.thresh;
      end else if (reg_addr == REG_WAIT) begin
        r_next.rdata = {6'h00, r_reg.wait_t};
      end else if (reg_addr == REG_STOP_FORCE) begin
        r_next.rdata = {9'h000, r_reg.stop_f};
      end else if (reg_addr == REG_STOP_DUR) begin
        r_next.rdata = {6'h00, r_reg.stop_d};
      end else if (reg_addr == REG_START_FORCE) begin
        r_next.rdata = {9'h000, r_reg.start_f};
      end else if (reg_addr == REG_START_DUR) begin
        r_next.rdata = {6'h00, r_reg.start_d};
      end else if (reg_addr == REG_CARRIER) begin
        r_next.rdata = {8'h00, r_reg.carrier};
      end else if (reg_addr == REG_TERM01) begin
        r_next.rdata = r_reg.tfunc[15:0];
      end else if (reg_addr == REG_TERM23) begin
        r_next.rdata = r_reg.tfunc[31:16];
      end else if (reg_addr == REG_TERM45) begin
        r_next.rdata = r_reg.tfunc[47:32];
      end else if (reg_addr == REG_TERM67) begin
        r_next.rdata = r_reg.tfunc[63:48];
      end else if (reg_addr == REG_STATUS) begin
        r_next.rdata = {6'h00, r_reg.timer[5:0], r_reg.kind, r_reg.state};
      end
    end
    // sequencer
    case (r_reg.state)
      // idle: a terminal trigger wins over the start paths
      S_OFF: begin
        if (ext_go) begin
          r_next.state = S_WAIT;
          r_next.kind  = K_EXT;
          r_next.timer = r_reg.wait_t;
        end else if (run_cmd && thr_mode && low) begin
          r_next.state = S_BRAKE;
          r_next.kind  = K_THR;
          r_next.timer = r_reg.stop_d;
        end else if (run_cmd && en == EN_INT && r_reg.start_d != 10'h000) begin
          r_next.state = S_BRAKE;
          r_next.kind  = K_START;
          r_next.timer = r_reg.start_d;
        end else if (run_cmd) begin
          r_next.state = S_RUN;
        end
      end
      // driving: terminal, internal stop or threshold braking
      S_RUN: begin
        if (ext_go) begin
          r_next.state = S_WAIT;
          r_next.kind  = K_EXT;
          r_next.timer = r_reg.wait_t;
        end else if (!run_cmd && en == EN_INT && out_freq <= r_reg.thresh) begin
          r_next.state = S_WAIT;
          r_next.kind  = K_STOP;
          r_next.timer = r_reg.wait_t;
        end else if (!run_cmd && en != EN_INT) begin
          r_next.state = S_OFF;
        end else if (run_cmd && thr_mode && low) begin
          r_next.state = S_BRAKE;
          r_next.kind  = K_THR;
          r_next.timer = r_reg.stop_d;
        end
      end
      S_WAIT: begin
        // output off, motor coasts until delay ends
        if (r_reg.kind == K_EXT && det == DET_LEVEL && !ext) begin
          r_next.state = run_cmd ? S_RUN : S_OFF;
        end else if (tdone) begin
          r_next.state = S_BRAKE;
          r_next.timer = r_reg.stop_d;
        end
      end
      // braking: the exit depends on the cause and the detect mode
      S_BRAKE: begin
        if (r_reg.kind == K_THR) begin
          // run off stops; the hysteresis limit resumes normal output
          if (!run_cmd) begin
            r_next.state = S_OFF;
          end else if (hi && (det == DET_LEVEL || tdone)) begin
            r_next.state = S_RUN;
          end
        end else if (r_reg.kind == K_EXT && det == DET_LEVEL) begin
          // level terminal braking lasts while the terminal is held
          if (!ext) begin
            r_next.state = run_cmd ? S_RUN : S_OFF;
          end
        end else if (r_reg.kind == K_START) begin
          // start braking always runs its full duration
          if (tdone) begin
            r_next.state = run_cmd ? S_RUN : S_OFF;
          end
        end else if (det == DET_EDGE) begin
          // edge mode: the duration has priority over run changes
          if (tdone) begin
            r_next.state = run_cmd ? S_RUN : S_OFF;
          end
        end else if (tdone || run_rise) begin
          // a new run command cuts level-mode stop braking short
          r_next.state = run_cmd ? S_RUN : S_OFF;       // level-mode stop braking
        end
      end
      default: begin
        r_next.state = S_OFF;
      end
    endcase
    // restart the timebase on each state change so the first step is full
    if (r_next.state != r_reg.state) begin
      r_next.step_cnt = 24'h00_0000;
    end
    // registered stage enable and current level
    r_next.stage = (r_next.state == S_RUN) || (r_next.state == S_BRAKE);
    if (r_next.state != S_BRAKE) begin
      r_next.level = 7'h00;
    end else if (r_next.kind == K_START) begin
      r_next.level = start_lv;
    end else begin
      r_next.level = stop_lv;
    end
  end

  // state register
  // synchronous reset clears settings and state together
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // read data, stage enable and level straight from flip-flops
  // braking flag decoded from the state register
  assign reg_rdata     = r_reg.rdata;
  assign stage_enable  = r_reg.stage;
  assign brake_active  = (r_reg.state == S_BRAKE);
  assign brake_level   = r_reg.level;
  // carrier held within its allowed range
  assign brake_carrier = (r_reg.carrier < CAR_MIN) ? CAR_MIN :
                         (r_reg.carrier > cmax) ? cmax : r_reg.carrier;

  // checks
  a_thr_blocks: assert property (@(posedge core_clk) disable iff (rst)
    (thr_mode && r_reg.state == S_OFF)
    |=> !(r_reg.kind == K_EXT && r_reg.state inside {S_WAIT, S_BRAKE}))
    else $error("terminal braking accepted in threshold mode");
  a_wait_coast: assert property (@(posedge core_clk) disable iff (rst)
    r_reg.state == S_WAIT |-> !stage_enable && brake_level == 7'h00)
    else $error("output stage on during wait");
  a_stop_level: assert property (@(posedge core_clk) disable iff (rst)
    (brake_active && r_reg.kind != K_START) |-> brake_level == $past(stop_lv))
    else $error("wrong stop braking level");
  a_start_level: assert property (@(posedge core_clk) disable iff (rst)
    (brake_active && r_reg.kind == K_START) |-> brake_level == $past(start_lv))
    else $error("wrong start braking level");
  a_force_max: assert property (@(posedge core_clk) disable iff (rst)
    brake_level <= $past(fmax))
    else $error("braking level above ceiling");
  a_thr_run: assert property (@(posedge core_clk) disable iff (rst)
    (brake_active && r_reg.kind == K_THR) |-> $past(run_cmd))
    else $error("threshold braking without run");
  a_edge_hold: assert property (@(posedge core_clk) disable iff (rst)
    (brake_active && det == DET_EDGE && r_reg.kind inside {K_STOP, K_EXT}
     && r_reg.timer > 10'h001) |=> brake_active)
    else $error("edge braking ended early");
  a_level_release: assert property (@(posedge core_clk) disable iff (rst)
    (brake_active && r_reg.kind == K_EXT && det == DET_LEVEL && !ext) |=> !brake_active)
    else $error("level braking held after release");
  a_stop_entry: assert property (@(posedge core_clk) disable iff (rst)
    (r_reg.state == S_RUN && en == EN_INT && !run_cmd && !ext_go
     && out_freq <= r_reg.thresh) |=> r_reg.state == S_WAIT && !stage_enable)
    else $error("stop braking did not begin with coast");
  a_thr_exit: assert property (@(posedge core_clk) disable iff (rst)
    (brake_active && r_reg.kind == K_THR && run_cmd && hi && det == DET_LEVEL)
    |=> r_reg.state == S_RUN)
    else $error("threshold braking not released");
  // entry checks for the start, threshold and terminal paths
  a_start_entry: assert property (@(posedge core_clk) disable iff (rst)
    (r_reg.state == S_OFF && en == EN_INT && run_cmd && !ext_go
     && r_reg.start_d != 10'h000) |=> brake_active && r_reg.kind == K_START)
    else $error("start braking did not begin at run");
  a_thr_zero_start: assert property (@(posedge core_clk) disable iff (rst)
    (r_reg.state == S_OFF && thr_mode && run_cmd && low)
    |=> brake_active && r_reg.kind == K_THR)
    else $error("low command start without braking");
  a_thr_high_start: assert property (@(posedge core_clk) disable iff (rst)
    (r_reg.state == S_OFF && thr_mode && run_cmd && !low)
    |=> r_reg.state == S_RUN && !brake_active)
    else $error("high command start began with braking");
  a_ext_entry: assert property (@(posedge core_clk) disable iff (rst)
    (r_reg.state == S_OFF && ext_go) |=> r_reg.state == S_WAIT && r_reg.kind == K_EXT)
    else $error("terminal trigger not accepted");

  // coverage of the main braking scenarios
  c_start_brake: cover property (@(posedge core_clk) disable iff (rst)
    brake_active && r_reg.kind == K_START);
  c_stop_brake: cover property (@(posedge core_clk) disable iff (rst)
    r_reg.state == S_WAIT ##1 brake_active && r_reg.kind == K_STOP);
  c_ext_brake: cover property (@(posedge core_clk) disable iff (rst)
    brake_active && r_reg.kind == K_EXT);
  c_thr_brake: cover property (@(posedge core_clk) disable iff (rst)
    brake_active && r_reg.kind == K_THR ##1 r_reg.state == S_RUN);
  c_level_brake: cover property (@(posedge core_clk) disable iff (rst)
    brake_active && r_reg.kind == K_EXT && det == DET_LEVEL);

endmodule : dbs_sequencer

// ===== core/dbs_pkg.sv
package dbs_pkg;
  // register indexes on the settings port
  localparam logic [3:0] REG_CTRL        = 4'h0;
  localparam logic [3:0] REG_THRESH      = 4'h1;
  localparam logic [3:0] REG_WAIT        = 4'h2;
  localparam logic [3:0] REG_STOP_FORCE  = 4'h3;
  localparam logic [3:0] REG_STOP_DUR    = 4'h4;
  localparam logic [3:0] REG_START_FORCE = 4'h5;
  localparam logic [3:0] REG_START_DUR   = 4'h6;
  localparam logic [3:0] REG_CARRIER     = 4'h7;
  localparam logic [3:0] REG_TERM01      = 4'h8;
  localparam logic [3:0] REG_TERM23      = 4'h9;
  localparam logic [3:0] REG_TERM45      = 4'ha;
  localparam logic [3:0] REG_TERM67      = 4'hb;
  localparam logic [3:0] REG_STATUS      = 4'hc;
  // control register fields
  localparam int CTRL_EN_LSB  = 0;
  localparam int CTRL_DETECT  = 2;
  localparam int CTRL_VT      = 3;
  localparam int CTRL_LARGE   = 4;
  // setting codes
  localparam logic [1:0] EN_OFF    = 2'h0;
  localparam logic [1:0] EN_INT    = 2'h1;
  localparam logic [1:0] EN_THRESH = 2'h2;
  localparam logic       DET_EDGE  = 1'b0;
  localparam logic       DET_LEVEL = 1'b1;
  localparam logic [7:0] FUNC_BRAKE = 8'h07;
  localparam int         NUM_TERM  = 8;
  // limits, frequency in 0.01 Hz, times in 0.1 s, carrier in 0.1 kHz
  localparam logic [15:0] THRESH_MAX  = 16'h1770;
  localparam logic [15:0] THRESH_HYST = 16'h00c8;
  localparam logic [9:0]  WAIT_MAX    = 10'h032;
  localparam logic [9:0]  DUR_MAX     = 10'h258;
  localparam logic [6:0]  F_CT        = 7'h64;
  localparam logic [6:0]  F_CT_LARGE  = 7'h50;
  localparam logic [6:0]  F_VT        = 7'h46;
  localparam logic [6:0]  F_VT_LARGE  = 7'h32;
  localparam logic [7:0]  CAR_MIN      = 8'h05;
  localparam logic [7:0]  CAR_CT       = 8'h96;
  localparam logic [7:0]  CAR_CT_LARGE = 8'h64;
  localparam logic [7:0]  CAR_VT       = 8'h78;
  localparam logic [7:0]  CAR_VT_LARGE = 8'h50;
  // timebase: one timer step is 0.1 s
  localparam int CLK_HZ   = 10_000_000;
  localparam int STEP_MS  = 100;
  localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
  // sequencer states and braking causes
  typedef enum logic [1:0] {S_OFF, S_RUN, S_WAIT, S_BRAKE} dbs_state_type;
  typedef enum logic [1:0] {K_START, K_STOP, K_EXT, K_THR} dbs_kind_type;
endpackage : dbs_pkg

// ===== testbench/dbs_motor_model.sv
`timescale 1ns/1ns
// motor stand-in: speed follows the command while driven, runs down otherwise
module dbs_motor_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        run_cmd,
  input  wire logic [15:0] cmd_freq,
  input  wire logic        stage_enable,
  input  wire logic        brake_active,
  output logic      [15:0] out_freq
);
  logic [15:0] tgt_freq;  // speed the shaft heads for
  assign tgt_freq = (stage_enable && !brake_active && run_cmd) ? cmd_freq : 16'h0000;
  // 1 Hz per clock slew, so threshold crossings take a few cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_freq <= 16'h0000;
    end else if (out_freq + 16'h0064 <= tgt_freq) begin
      out_freq <= out_freq + 16'h0064;
    end else if (out_freq >= tgt_freq + 16'h0064) begin
      out_freq <= out_freq - 16'h0064;
    end else begin
      out_freq <= tgt_freq;
    end
  end
endmodule : dbs_motor_model

// ===== testbench/dbs_sequencer_tb.sv
`timescale 1ns/1ns
module dbs_sequencer_tb;
  import dbs_pkg::*;
  localparam int STEP = 10;  // short timer step for simulation
  logic        core_clk  = 1'b0;
  logic        rst       = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        run_cmd   = 1'b0;
  logic [7:0]  term_in   = 8'h00;
  logic [15:0] cmd_freq  = 16'h0000;
  logic [15:0] reg_rdata, out_freq;
  logic        stage_enable, brake_active;
  logic [6:0]  brake_level;
  logic [7:0]  brake_carrier;
  int          errors     = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  int          n;

  dbs_sequencer #(.STEP_CYCLES(STEP)) i_dut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .run_cmd(run_cmd), .term_in(term_in), .cmd_freq(cmd_freq),
    .out_freq(out_freq), .stage_enable(stage_enable), .brake_active(brake_active),
    .brake_level(brake_level), .brake_carrier(brake_carrier));
  dbs_motor_model i_motor (.core_clk(core_clk), .rst(rst), .run_cmd(run_cmd),
    .cmd_freq(cmd_freq), .stage_enable(stage_enable), .brake_active(brake_active),
    .out_freq(out_freq));

  // 10 MHz clock
  always #50 core_clk = ~core_clk;
  // hang guard: the whole run needs well under 2000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  // cycle counts are judged against a window
  task automatic check_in(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_in

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 check(what, exp, reg_rdata);
  endtask : rchk

  // count edges until stage_enable (sel=1) or brake_active reaches val
  task automatic wait_out(input bit sel, input logic val, input int maxc, output int cnt);
    cnt = 0;
    do begin
      @(posedge core_clk);
      #1 cnt++;
    end while ((sel ? stage_enable : brake_active) !== val && cnt < maxc);
  endtask : wait_out

  task automatic test_regs();
    check("carrier", 16'h0005, {8'h00, brake_carrier});
    check("level", 16'h0000, {9'h000, brake_level});
    rchk("status", REG_STATUS, 16'h0000);
    wr(REG_THRESH, 16'hffff);
    rchk("threshold", REG_THRESH, THRESH_MAX);
    wr(REG_WAIT, 16'h00ff);
    rchk("wait", REG_WAIT, {6'h00, WAIT_MAX});
    wr(REG_STOP_DUR, 16'h0400);
    rchk("stop dur", REG_STOP_DUR, {6'h00, DUR_MAX});
    rchk("unmapped", 4'hd, 16'h0000);
    wr(REG_START_DUR, 16'h0800);
    rchk("start dur", REG_START_DUR, {6'h00, DUR_MAX});
    #100 check("rdata idle", 16'h0000, reg_rdata);
    $display("test regs done");
  endtask : test_regs

  task automatic test_stop();
    wr(REG_CTRL, 16'h0001);
    wr(REG_THRESH, 16'h01f4);
    wr(REG_WAIT, 16'h0002);
    wr(REG_STOP_DUR, 16'h0003);
    wr(REG_START_DUR, 16'h0000);
    wr(REG_STOP_FORCE, 16'h007f);
    wr(REG_CARRIER, 16'h00c8);
    cmd_freq <= 16'h03e8;
    run_cmd  <= 1'b1;
    wait_out(1, 1'b1, 5, n);
    check("no start brake", 16'h0000, {15'h0, brake_active});
    repeat (15) @(posedge core_clk);
    run_cmd <= 1'b0;
    wait_out(1, 1'b0, 20, n);
    check_in("coast entry", 1, 12, n);
    wait_out(0, 1'b1, 40, n);
    check_in("wait delay", 19, 23, n);
    check("stage", 16'h0001, {15'h0, stage_enable});
    check("stop level", 16'h0064, {9'h000, brake_level});
    check("carrier ct", {8'h00, CAR_CT}, {8'h00, brake_carrier});
    wait_out(0, 1'b0, 40, n);
    check_in("stop duration", 28, 34, n);
    check("stage off", 16'h0000, {15'h0, stage_enable});
    $display("test stop done");
  endtask : test_stop

  task automatic test_start();
    wr(REG_START_FORCE, 16'h003c);
    wr(REG_START_DUR, 16'h0002);
    wr(REG_WAIT, 16'h0000);
    wr(REG_STOP_DUR, 16'h0000);
    for (int d = 0; d < 2; d++) begin
      wr(REG_CTRL, 16'h0001 | 16'(d << CTRL_DETECT));
      run_cmd <= 1'b1;
      wait_out(0, 1'b1, 4, n);
      check_in("start entry", 1, 3, n);
      check("start level", 16'h003c, {9'h000, brake_level});
      wait_out(0, 1'b0, 30, n);
      check_in("start duration", 17, 23, n);
      check("run stage", 16'h0001, {15'h0, stage_enable});
      run_cmd <= 1'b0;
      repeat (30) @(posedge core_clk);
    end
    $display("test start done");
  endtask : test_start

  task automatic test_ext_edge();
    wr(REG_CTRL, 16'h0000);
    wr(REG_TERM45, 16'h0700);
    wr(REG_STOP_FORCE, 16'h0028);
    wr(REG_STOP_DUR, 16'h0003);
    term_in <= 8'h10;
    @(posedge core_clk);
    term_in <= 8'h00;
    wait_out(0, 1'b1, 5, n);
    check("other terminal", 16'h0000, {15'h0, brake_active});
    term_in <= 8'h20;
    @(posedge core_clk);
    term_in <= 8'h00;
    wait_out(0, 1'b1, 6, n);
    check_in("ext entry", 1, 5, n);
    check("ext level", 16'h0028, {9'h000, brake_level});
    run_cmd <= 1'b1;
    repeat (5) @(posedge core_clk);
    run_cmd <= 1'b0;
    wait_out(0, 1'b0, 40, n);
    check_in("edge duration", 20, 29, n);
    $display("test ext edge done");
  endtask : test_ext_edge

  task automatic test_ext_level();
    wr(REG_CTRL, 16'h001c);
    wr(REG_STOP_FORCE, 16'h007f);
    term_in <= 8'h20;
    wait_out(0, 1'b1, 6, n);
    check_in("level entry", 1, 5, n);
    check("vt large level", {9'h000, F_VT_LARGE}, {9'h000, brake_level});
    check("vt large carrier", {8'h00, CAR_VT_LARGE}, {8'h00, brake_carrier});
    wait_out(0, 1'b0, 45, n);
    check_in("level held", 45, 45, n);
    term_in <= 8'h00;
    wait_out(0, 1'b0, 4, n);
    check_in("level release", 1, 3, n);
    $display("test ext level done");
  endtask : test_ext_level

  task automatic test_thresh();
    wr(REG_CTRL, 16'h0006);
    wr(REG_STOP_FORCE, 16'h0028);
    cmd_freq <= 16'h0000;
    run_cmd  <= 1'b1;
    wait_out(0, 1'b1, 4, n);
    check_in("zero start", 1, 3, n);
    check("thr level", 16'h0028, {9'h000, brake_level});
    cmd_freq <= 16'h028a;
    wait_out(0, 1'b0, 10, n);
    check_in("below hysteresis", 10, 10, n);
    cmd_freq <= 16'h02bc;
    wait_out(0, 1'b0, 4, n);
    check_in("hysteresis exit", 1, 3, n);
    check("resume stage", 16'h0001, {15'h0, stage_enable});
    term_in <= 8'h20;
    @(posedge core_clk);
    term_in <= 8'h00;
    wait_out(0, 1'b1, 6, n);
    check("terminal blocked", 16'h0000, {15'h0, brake_active});
    cmd_freq <= 16'h012c;
    wait_out(0, 1'b1, 15, n);
    check_in("both low", 2, 10, n);
    run_cmd <= 1'b0;
    wait_out(1, 1'b0, 4, n);
    check_in("run off", 1, 3, n);
    check("no brake idle", 16'h0000, {15'h0, brake_active});
    cmd_freq <= 16'h03e8;
    run_cmd  <= 1'b1;
    wait_out(0, 1'b1, 5, n);
    check("high start", 16'h0000, {15'h0, brake_active});
    check("high stage", 16'h0001, {15'h0, stage_enable});
    run_cmd <= 1'b0;
    // edge mode: threshold braking holds for the stop duration
    repeat (10) @(posedge core_clk);
    wr(REG_CTRL, 16'h0002);
    cmd_freq <= 16'h0000;
    run_cmd  <= 1'b1;
    wait_out(0, 1'b1, 4, n);
    check_in("edge thr entry", 1, 3, n);
    cmd_freq <= 16'h02bc;
    wait_out(0, 1'b0, 40, n);
    check_in("edge thr exit", 28, 34, n);
    check("edge thr stage", 16'h0001, {15'h0, stage_enable});
    run_cmd <= 1'b0;
    $display("test thresh done");
  endtask : test_thresh

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    test_regs();
    test_stop();
    test_start();
    test_ext_edge();
    test_ext_level();
    test_thresh();
    tally_and_finish();
  end
endmodule : dbs_sequencer_tb
